// ==== hdl/tlj_cfg.svh ====
// constants of the line interface and jitter attenuator
`ifndef TLJ_CFG_SVH
`define TLJ_CFG_SVH

// ****************************************
// register map
// ****************************************
`define TLJ_LINE_INTERFACE_CONTROL_OFS 8'h7c
`define TLJ_RECEIVE_INFO_REG3_OFS 8'h80
`define TLJ_LINE_INTERFACE_CONTROL_RST 8'h00
`define TLJ_ATTENUATOR_LIMIT_TRIP_BIT 5
`define TLJ_LOS_BIT 0
`define TLJ_CSU_FIRST 3'h5
`define TLJ_RESP_OK 2'h0
`define TLJ_RESP_ERR 2'h2

// ****************************************
// timing
// ****************************************
`define TLJ_CLK_KHZ 250000
`define TLJ_OS_KHZ 24704
`define TLJ_OS_PER_BIT 4'h8
`define TLJ_DIV_FAST 5'h0f
`define TLJ_DIV_NOM 5'h10
`define TLJ_DIV_SLOW 5'h11
`define TLJ_LOS_BITS 8'hc0

// ****************************************
// attenuator depths
// ****************************************
`define TLJ_DEPTH_L 128
`define TLJ_DEPTH_S 32
`define TLJ_JIT_L 120
`define TLJ_JIT_S 28
`define TLJ_MRG_L ((`TLJ_DEPTH_L - `TLJ_JIT_L) / 2)
`define TLJ_MRG_S ((`TLJ_DEPTH_S - `TLJ_JIT_S) / 2)
`define TLJ_FIFO_W 8
`define TLJ_FIFO_D 16

`endif

// ==== hdl/tlj_fifo.sv ====
// byte fifo between the attenuator and the framer side
`timescale 1ns/10ps
`default_nettype none

module tlj_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // fill side
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // drain side
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } tlj_fifo_st_t;

   tlj_fifo_st_t st;
   tlj_fifo_st_t next_st;
   logic full;
   logic empty;

   // depth must be a power of two: the pointers wrap by their extra bit
   assign full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
   assign empty = (st.wp == st.rp);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = st.mem[st.rp[AW-1:0]];

   always_comb begin
      next_st = st;
      if (in_valid_i && !full) begin
         next_st.mem[st.wp[AW-1:0]] = in_data_i;
         next_st.wp = st.wp + 1'b1;
      end
      if (out_ready_i && !empty) begin
         next_st.rp = st.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : tlj_fifo

`default_nettype wire

// ==== hdl/tlj_jabuf.sv ====
// bit memory of the jitter attenuator with registered read
`timescale 1ns/10ps
`default_nettype none
`include "tlj_cfg.svh"

module tlj_jabuf (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // write port
   input wire logic we_i,
   input wire logic [6:0] waddr_i,
   input wire logic wbit_i,
   // read port
   input wire logic re_i,
   input wire logic [6:0] raddr_i,
   output logic rbit_o
);
   typedef struct packed {
      logic [`TLJ_DEPTH_L-1:0] m;
      logic q;
   } tlj_jabuf_st_t;

   tlj_jabuf_st_t st;
   tlj_jabuf_st_t next_st;

   assign rbit_o = st.q;

   always_comb begin
      next_st = st;
      if (we_i) begin
         next_st.m[waddr_i] = wbit_i;
      end
      if (re_i) begin
         next_st.q = st.m[raddr_i];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : tlj_jabuf

`default_nettype wire

// ==== hdl/tlj_pkg.sv ====
// types of the line interface and jitter attenuator
package tlj_pkg;

   typedef struct packed {
      logic [2:0] build_out_select;
      logic receive_gain_limit;
      logic attenuator_path_select;
      logic attenuator_depth_select;
      logic attenuator_disable;
      logic transmitter_power_down;
   } tlj_line_interface_control_t;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } tlj_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } tlj_axi_rsp_t;

   typedef struct packed {
      tlj_line_interface_control_t line_interface_control;
      logic attenuator_limit_trip;
      logic los;
      logic aw_got;
      logic w_got;
      logic [7:0] awa;
      logic [31:0] wd;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [17:0] acc;
      logic [3:0] osf;
      logic [3:0] ph;
      logic mprev;
      logic mseen;
      logic [7:0] zeros;
      logic tclk_q;
      logic [6:0] wptr;
      logic [6:0] rptr;
      logic [4:0] sdiv;
      logic [4:0] sper;
      logic align;
      logic [2:0] cfg_q;
      logic ja_vld;
      logic [7:0] sh;
      logic [2:0] nbits;
      logic txpol;
      logic txp;
      logic txn;
      logic recovered_clock_out;
   } tlj_st_t;

endpackage : tlj_pkg

// ==== hdl/tlj_top.sv ====
// t1 line interface: clock recovery, build-out select, jitter attenuator
// Behaviour
// - three-bit build-out code: 0..4 short-haul lengths, 5..7 CSU attenuations
// - depth bit clear gives a 128-bit attenuator, set gives 32 bits
// - path bit places the attenuator in receive or transmit data path
// - disable bit bypasses the attenuator in both paths
// - master clock feeds a fractional divider giving a sixteen-times oversampler for recovery
// - carrier loss is declared while no AMI marks arrive on the line
// - recovered clock output follows master clock during carrier loss
// - near 50% duty with attenuator in receive path, else shortened highs
// - smoothed clock reads the attenuator; writes use the selected input clock
// - gapped transmit clock is accepted and still yields a smooth output
// - near overflow or underflow the smoothing rate is altered temporarily
// - smoothing divides oversample clock by sixteen, by fifteen or seventeen correcting
// - any fifteen or seventeen division sets the limit-trip status flag
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tlj_cfg.svh"

module tlj_top (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic ARST_N_I,
   // register bus
   input wire tlj_pkg::tlj_axi_req_t AXI_REQ_I,
   output tlj_pkg::tlj_axi_rsp_t AXI_RSP_O,
   // receive line
   input wire logic LINE_RX_POS_I,
   input wire logic LINE_RX_NEG_I,
   // receive side toward the framer
   output logic RECOVERED_CLOCK_OUT_O,
   output logic RX_CARRIER_LOSS_O,
   output logic [7:0] RX_BYTE_O,
   output logic RX_VALID_O,
   input wire logic RX_READY_I,
   // transmit side from the formatter
   input wire logic TRANSMIT_CLK_I,
   input wire logic TX_DATA_I,
   // transmit line
   output logic LINE_TX_POS_O,
   output logic LINE_TX_NEG_O,
   output logic LINE_TX_OE_O,
   // analog front-end controls and status
   output logic [2:0] BUILD_OUT_O,
   output logic CSU_MODE_O,
   output logic RX_GAIN_LIMIT_O,
   output logic LIMIT_TRIP_O
);
   import tlj_pkg::*;

   tlj_st_t st;
   tlj_st_t next_st;

   // ****************************************
   // combinational helpers
   // ****************************************
   logic [18:0] acc_sum;
   logic os;
   logic mark;
   logic rstb;
   logic tstb;
   logic ja_on, ja_rx, ja_tx;
   logic [6:0] mask, half, mrg, fill;
   logic wstb, wbit, ja_rd, rd_bit;
   logic rx_s, rx_b, tx_s, tx_b;
   logic push, fifo_rdy, cfg_chg;
   logic [7:0] push_byte;
   logic aw_hs, w_hs, ar_hs, wr_do;
   logic [31:0] rd_val;
   logic rd_ok;

   // ****************************************
   // oversample clock
   // ****************************************
   // fractional accumulator: the 16x rate cannot divide 250 MHz exactly
   assign acc_sum = {1'b0, st.acc} + 19'(`TLJ_OS_KHZ);
   assign os = (acc_sum >= 19'(`TLJ_CLK_KHZ));

   // ****************************************
   // receive recovery
   // ****************************************
   assign mark = LINE_RX_POS_I | LINE_RX_NEG_I;
   assign rstb = os && (st.ph == `TLJ_OS_PER_BIT);
   assign tstb = TRANSMIT_CLK_I && !st.tclk_q;

   // ****************************************
   // attenuator configuration
   // ****************************************
   assign ja_on = !st.line_interface_control.attenuator_disable;
   assign ja_rx = ja_on && !st.line_interface_control.attenuator_path_select;
   assign ja_tx = ja_on && st.line_interface_control.attenuator_path_select;
   assign mask = st.line_interface_control.attenuator_depth_select ? 7'(`TLJ_DEPTH_S - 1)
                                                 : 7'(`TLJ_DEPTH_L - 1);
   assign half = st.line_interface_control.attenuator_depth_select ? 7'(`TLJ_DEPTH_S / 2)
                                                 : 7'(`TLJ_DEPTH_L / 2);
   assign mrg = st.line_interface_control.attenuator_depth_select ? 7'(`TLJ_MRG_S) : 7'(`TLJ_MRG_L);
   assign fill = 7'(st.wptr - st.rptr) & mask;
   assign cfg_chg = (st.cfg_q != {st.line_interface_control.attenuator_path_select,
                                  st.line_interface_control.attenuator_depth_select,
                                  st.line_interface_control.attenuator_disable});

   // write side runs on the incoming clock of the selected path
   assign wstb = ja_on && !st.align && (ja_tx ? tstb : rstb);
   assign wbit = ja_tx ? TX_DATA_I : st.mseen;

   // a full byte fifo holds the read off, so back-pressure reaches the attenuator
   assign rd_ok = !ja_rx || fifo_rdy || (st.nbits != 3'h7);
   assign ja_rd = ja_on && os && !st.align && rd_ok
                  && (st.sdiv == 5'(st.sper - 5'h1));

   // ****************************************
   // data path selection
   // ****************************************
   assign rx_s = ja_rx ? st.ja_vld : rstb;
   assign rx_b = ja_rx ? rd_bit : st.mseen;
   assign tx_s = ja_tx ? st.ja_vld : tstb;
   assign tx_b = ja_tx ? rd_bit : TX_DATA_I;
   assign push = rx_s && (st.nbits == 3'h7);
   assign push_byte = {st.sh[6:0], rx_b};

   // ****************************************
   // register bus
   // ****************************************
   assign aw_hs = AXI_REQ_I.awvalid && !st.aw_got && !st.bvalid;
   assign w_hs = AXI_REQ_I.wvalid && !st.w_got && !st.bvalid;
   assign ar_hs = AXI_REQ_I.arvalid && !st.rvalid;
   assign wr_do = st.aw_got && st.w_got && !st.bvalid;

   always_comb begin
      rd_val = '0;
      if (AXI_REQ_I.araddr == `TLJ_LINE_INTERFACE_CONTROL_OFS) begin
         rd_val[7:0] = st.line_interface_control;
      end else if (AXI_REQ_I.araddr == `TLJ_RECEIVE_INFO_REG3_OFS) begin
         rd_val[`TLJ_ATTENUATOR_LIMIT_TRIP_BIT] = st.attenuator_limit_trip;
         rd_val[`TLJ_LOS_BIT] = st.los;
      end
   end

   always_comb begin
      AXI_RSP_O = '0;
      AXI_RSP_O.awready = !st.aw_got && !st.bvalid;
      AXI_RSP_O.wready = !st.w_got && !st.bvalid;
      AXI_RSP_O.bresp = st.bresp;
      AXI_RSP_O.bvalid = st.bvalid;
      AXI_RSP_O.arready = !st.rvalid;
      AXI_RSP_O.rdata = st.rdata;
      AXI_RSP_O.rresp = st.rresp;
      AXI_RSP_O.rvalid = st.rvalid;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_st = st;
      // bus write: address and data may come in either order
      if (aw_hs) begin
         next_st.aw_got = 1'b1;
         next_st.awa = AXI_REQ_I.awaddr;
      end
      if (w_hs) begin
         next_st.w_got = 1'b1;
         next_st.wd = AXI_REQ_I.wdata;
         if (!AXI_REQ_I.wstrb[0]) begin
            next_st.wd[7:0] = st.line_interface_control;
         end
      end
      if (wr_do) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = `TLJ_RESP_OK;
         if (st.awa == `TLJ_LINE_INTERFACE_CONTROL_OFS) begin
            next_st.line_interface_control = st.wd[7:0];
         end else if (st.awa != `TLJ_RECEIVE_INFO_REG3_OFS) begin
            next_st.bresp = `TLJ_RESP_ERR;
         end
      end
      if (st.bvalid && AXI_REQ_I.bready) begin
         next_st.bvalid = 1'b0;
      end
      // bus read: reading the status word clears the trip flag
      if (st.rvalid && AXI_REQ_I.rready) begin
         next_st.rvalid = 1'b0;
      end
      if (ar_hs) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_val;
         next_st.rresp = `TLJ_RESP_OK;
         if (AXI_REQ_I.araddr == `TLJ_RECEIVE_INFO_REG3_OFS) begin
            next_st.attenuator_limit_trip = 1'b0;
         end else if (AXI_REQ_I.araddr != `TLJ_LINE_INTERFACE_CONTROL_OFS) begin
            next_st.rresp = `TLJ_RESP_ERR;
         end
      end

      // oversampler and free running master-derived bit clock
      next_st.acc = os ? 18'(acc_sum - 19'(`TLJ_CLK_KHZ)) : st.acc + 18'(`TLJ_OS_KHZ);
      if (os) begin
         next_st.osf = st.osf + 4'h1;
         next_st.mprev = mark;
         // each mark edge recentres the bit phase
         next_st.ph = (mark && !st.mprev) ? 4'h1 : st.ph + 4'h1;
         // the sample tick opens a fresh slot: a pulse tail seen there is not a new mark
         next_st.mseen = rstb ? 1'b0 : (st.mseen | mark);
      end
      if (rstb) begin
         if (st.mseen) begin
            next_st.zeros = '0;
         end else if (st.zeros != 8'hff) begin
            next_st.zeros = st.zeros + 8'h1;
         end
      end
      next_st.los = (next_st.zeros >= `TLJ_LOS_BITS);
      next_st.tclk_q = TRANSMIT_CLK_I;

      // recovered clock pin
      if (st.los) begin
         next_st.recovered_clock_out = st.osf[3];
      end else if (ja_rx) begin
         next_st.recovered_clock_out = (st.sdiv < (st.sper >> 1));
      end else begin
         next_st.recovered_clock_out = (st.ph != 4'h0) && (st.ph < `TLJ_OS_PER_BIT);
      end

      // attenuator write side
      if (wstb) begin
         next_st.wptr = (st.wptr + 7'h1) & mask;
      end

      // smoothing divider, period chosen at each read
      if (os && !ja_rd && (st.sdiv != 5'(st.sper - 5'h1))) begin
         next_st.sdiv = st.sdiv + 5'h1;
      end
      next_st.ja_vld = ja_rd;
      if (ja_rd) begin
         next_st.sdiv = '0;
         next_st.rptr = (st.rptr + 7'h1) & mask;
         if (fill >= 7'(mask - mrg)) begin
            next_st.sper = `TLJ_DIV_FAST;
         end else if (fill <= mrg) begin
            next_st.sper = `TLJ_DIV_SLOW;
         end else begin
            next_st.sper = `TLJ_DIV_NOM;
         end
         if (st.sper != `TLJ_DIV_NOM) begin
            next_st.attenuator_limit_trip = 1'b1;
         end
      end

      // realign after reset or any change of path, depth or disable
      next_st.cfg_q = {st.line_interface_control.attenuator_path_select,
                       st.line_interface_control.attenuator_depth_select,
                       st.line_interface_control.attenuator_disable};
      next_st.align = cfg_chg;
      if (st.align) begin
         next_st.rptr = 7'(st.wptr - half) & mask;
         next_st.wptr = st.wptr & mask;
         next_st.sdiv = '0;
         next_st.sper = `TLJ_DIV_NOM;
         next_st.ja_vld = 1'b0;
      end

      // receive byte assembly
      if (rx_s && (!push || fifo_rdy)) begin
         next_st.sh = push_byte;
         next_st.nbits = st.nbits + 3'h1;
      end

      // transmit AMI: marks alternate polarity
      if (tx_s) begin
         next_st.txp = tx_b && !st.txpol;
         next_st.txn = tx_b && st.txpol;
         if (tx_b) begin
            next_st.txpol = !st.txpol;
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st <= '0;
         st.line_interface_control <= `TLJ_LINE_INTERFACE_CONTROL_RST;
         st.align <= 1'b1;
         st.sper <= `TLJ_DIV_NOM;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // submodules
   // ****************************************
   tlj_jabuf u_jabuf (
      .clk_i(MCLK_I),
      .rst_n_i(ARST_N_I),
      .we_i(wstb),
      .waddr_i(st.wptr),
      .wbit_i(wbit),
      .re_i(ja_rd),
      .raddr_i(st.rptr),
      .rbit_o(rd_bit)
   );

   tlj_fifo #(
      .W(`TLJ_FIFO_W),
      .D(`TLJ_FIFO_D)
   ) u_fifo (
      .clk_i(MCLK_I),
      .rst_n_i(ARST_N_I),
      .in_data_i(push_byte),
      .in_valid_i(push),
      .in_ready_o(fifo_rdy),
      .out_data_o(RX_BYTE_O),
      .out_valid_o(RX_VALID_O),
      .out_ready_i(RX_READY_I)
   );

   // ****************************************
   // outputs
   // ****************************************
   assign RECOVERED_CLOCK_OUT_O = st.recovered_clock_out;
   assign RX_CARRIER_LOSS_O = st.los;
   assign LINE_TX_POS_O = st.txp;
   assign LINE_TX_NEG_O = st.txn;
   assign LINE_TX_OE_O = !st.line_interface_control.transmitter_power_down;
   assign BUILD_OUT_O = st.line_interface_control.build_out_select;
   assign CSU_MODE_O = (st.line_interface_control.build_out_select >= `TLJ_CSU_FIRST);
   assign RX_GAIN_LIMIT_O = st.line_interface_control.receive_gain_limit;
   assign LIMIT_TRIP_O = st.attenuator_limit_trip;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!ARST_N_I);

   a_build_csu: assert property (CSU_MODE_O == (BUILD_OUT_O > 3'h4))
      else $error("build-out code and csu mode disagree");
   a_fill_depth: assert property (st.line_interface_control.attenuator_depth_select
      && !cfg_chg && !st.align |-> (st.wptr < 7'h20) && (st.rptr < 7'h20))
      else $error("attenuator fill beyond short depth");
   a_bypass_idle: assert property (st.line_interface_control.attenuator_disable |-> !ja_rd && !wstb)
      else $error("attenuator used while disabled");
   a_os_spacing: assert property (os |=> !os [*8])
      else $error("oversample ticks too close");
   a_mark_clears: assert property (rstb && st.mseen |=> !st.los)
      else $error("carrier loss held despite a mark");
   a_loss_clock: assert property ($past(st.los) |-> RECOVERED_CLOCK_OUT_O == $past(st.osf[3]))
      else $error("recovered clock not from master clock in loss");
   a_read_gap: assert property (ja_rd |=> !ja_rd [*8])
      else $error("smoothing reads too close");
   a_trip_set: assert property (ja_rd && st.sper != `TLJ_DIV_NOM |=> st.attenuator_limit_trip)
      else $error("limit trip not flagged");
   a_realign: assert property (st.align ##1 !st.align |-> fill == half)
      else $error("read pointer not half depth behind");

   c_trip: cover property ($rose(st.attenuator_limit_trip));
   c_loss: cover property ($rose(st.los));
   c_push: cover property (push && fifo_rdy && ja_rx);
   c_txja: cover property (ja_tx && st.ja_vld);

endmodule : tlj_top

`default_nettype wire

// ==== testbench/test_tlj_top.sv ====
// self-checking bench of the t1 line interface block
`timescale 1ns/10ps
`default_nettype none
`include "tlj_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end

module test_tlj_top;
   import tlj_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   tlj_axi_req_t req = '0;
   tlj_axi_rsp_t rsp;
   tlj_axi_rsp_t rs;
   logic rx_pos, rx_neg, rclk, los, rx_valid, tx_pos, tx_neg, tx_oe, csu, gain, trip;
   logic rx_ready = 1'b1;
   logic tclk = 1'b0;
   logic tdat = 1'b0;
   logic [7:0] rx_byte;
   logic [2:0] bo;
   logic rxq[$];
   logic expq[$];
   int fail_count = 0;
   int checked = 0;
   always #2 clk = ~clk;
   // outputs move only at rising edges, so a falling-edge copy is the pre-edge value
   always @(negedge clk) begin
      rs <= rsp;
      if (rx_valid === 1'b1 && rx_ready) begin
         for (int i = 7; i >= 0; i--) begin
            rxq.push_back(rx_byte[i]);
         end
      end
   end
   tlj_line_model line_u (.clk_i(clk), .pos_o(rx_pos), .neg_o(rx_neg));
   tlj_top dut_u (
      .MCLK_I(clk), .ARST_N_I(rst_n), .AXI_REQ_I(req), .AXI_RSP_O(rsp),
      .LINE_RX_POS_I(rx_pos), .LINE_RX_NEG_I(rx_neg), .RECOVERED_CLOCK_OUT_O(rclk),
      .RX_CARRIER_LOSS_O(los), .RX_BYTE_O(rx_byte), .RX_VALID_O(rx_valid),
      .RX_READY_I(rx_ready), .TRANSMIT_CLK_I(tclk), .TX_DATA_I(tdat),
      .LINE_TX_POS_O(tx_pos), .LINE_TX_NEG_O(tx_neg), .LINE_TX_OE_O(tx_oe),
      .BUILD_OUT_O(bo), .CSU_MODE_O(csu), .RX_GAIN_LIMIT_O(gain), .LIMIT_TRIP_O(trip)
   );
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      req.awaddr <= a;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge clk);
         aw = aw && !rs.awready;
         w = w && !rs.wready;
         req.awvalid <= aw;
         req.wvalid <= w;
      end while (rs.bvalid !== 1'b1);
      r = rs.bresp;
      req.bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar;
      ar = 1'b1;
      @(posedge clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         ar = ar && !rs.arready;
         req.arvalid <= ar;
      end while (rs.rvalid !== 1'b1);
      d = rs.rdata;
      r = rs.rresp;
      req.rready <= 1'b0;
   endtask : rd
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   initial begin
      #300000;
      fail_count++;
      final_report();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      logic [1:0] r;
      logic [31:0] d;
      logic [7:0] v;
      logic b;
      logic ep;
      logic first;
      int n;
      void'($urandom(32'hef3ea1bc));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(`TLJ_LINE_INTERFACE_CONTROL_OFS, d, r);
      `CHK({r, d}, {2'h0, 24'h0, `TLJ_LINE_INTERFACE_CONTROL_RST})
      for (int c = 0; c < 8; c++) begin
         v = {c[2:0], 5'($urandom())};
         wr(`TLJ_LINE_INTERFACE_CONTROL_OFS, v, r);
         rd(`TLJ_LINE_INTERFACE_CONTROL_OFS, d, r);
         `CHK(d, {24'h0, v})
         `CHK({bo, csu, gain, tx_oe}, {v[7:5], v[7:5] >= 3'h5, v[4], ~v[0]})
      end
      wr(8'h40, 8'hff, r);
      `CHK(r, 2'h2)
      rd(8'h40, d, r);
      `CHK({r, d}, {2'h2, 32'h0})
      wr(`TLJ_LINE_INTERFACE_CONTROL_OFS, 8'h02, r);
      `CHK(r, 2'h0)
      // bypassed transmit, clock with random gaps
      first = 1'b1;
      ep = 1'b0;
      for (int i = 0; i < 16; i++) begin
         b = 1'($urandom());
         repeat (4 + $urandom() % 24) @(posedge clk);
         tclk <= 1'b1;
         tdat <= b;
         repeat (4) @(posedge clk);
         tclk <= 1'b0;
         if (b && first) ep = tx_pos;
         first = first && !b;
         `CHK({tx_pos, tx_neg}, b ? {ep, ~ep} : 2'b00)
         ep = ep ^ b;
      end
      // idle pair since time zero: loss near 192 slots of 16 ticks
      while (los !== 1'b1 && $time < 200000) @(posedge clk);
      `CHK(($time > 120000) && ($time < 132000), 1'b1)
      n = 0;
      ep = rclk;
      repeat (400) begin
         @(negedge clk);
         n += int'(rclk && !ep);
         ep = rclk;
      end
      `CHK(n inside {2, 3}, 1'b1)
      rd(`TLJ_RECEIVE_INFO_REG3_OFS, d, r);
      `CHK(d[`TLJ_LOS_BIT], 1'b1)
      // bypass first, then the short attenuator in the receive path
      for (int p = 0; p < 2; p++) begin
         rxq.delete();
         expq.delete();
         for (int i = 0; i < 4; i++) begin
            v = 8'($urandom()) | ((i == 0) ? 8'h80 : 8'h00);
            line_u.push(v);
            for (int k = 7; k >= 0; k--) begin
               expq.push_back(v[k]);
            end
         end
         wait (line_u.q.size() == 0);
         // room for half the short depth plus a byte still being assembled
         repeat (4000) @(posedge clk);
         `CHK(los, 1'b0)
         // byte framing is free-running, so align on the first mark
         while (rxq.size() > 0 && rxq[0] !== 1'b1) void'(rxq.pop_front());
         for (int k = 0; k < 32; k++) begin
            `CHK(rxq[k], expq[k])
         end
         wr(`TLJ_LINE_INTERFACE_CONTROL_OFS, 8'h04, r);
         `CHK(r, 2'h0)
      end
      // steady line rate keeps the fill near half depth: no correction expected
      rd(`TLJ_RECEIVE_INFO_REG3_OFS, d, r);
      `CHK({trip, d[`TLJ_ATTENUATOR_LIMIT_TRIP_BIT], d[`TLJ_LOS_BIT]}, 3'b000)
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(`TLJ_LINE_INTERFACE_CONTROL_OFS, d, r);
      `CHK(d, {24'h0, `TLJ_LINE_INTERFACE_CONTROL_RST})
      `CHK({los, trip, rx_valid, tx_oe}, 4'b0001)
      final_report();
   end
endmodule : test_tlj_top
`default_nettype wire

// ==== testbench/tlj_line_model.sv ====
// line partner: ami marks on the receive pair at the t1 bit rate
`timescale 1ns/10ps
`default_nettype none

module tlj_line_model (
   // clock
   input wire logic clk_i,
   // receive pair toward the device
   output logic pos_o,
   output logic neg_o
);
   // ****************************************
   // bit timing
   // ****************************************
   // 250 MHz over 1.544 MHz, rounded to whole cycles
   localparam int BIT_CYC = 162;
   logic q[$];
   logic cur = 1'b0;
   logic pol = 1'b0;
   int c = 0;
   initial begin
      pos_o = 1'b0;
      neg_o = 1'b0;
   end
   task automatic push(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         q.push_back(b[i]);
      end
   endtask : push
   // ****************************************
   // ami shaping
   // ****************************************
   // an empty queue sends zeros, so the pair carries no marks at all
   always @(posedge clk_i) begin
      if (c == 0) begin
         cur = (q.size() > 0) ? q.pop_front() : 1'b0;
         pol = pol ^ cur;
      end
      pos_o <= cur && pol && (c < BIT_CYC / 2);
      neg_o <= cur && !pol && (c < BIT_CYC / 2);
      c = (c + 1) % BIT_CYC;
   end
endmodule : tlj_line_model
`default_nettype wire
